//--- src/ps2c_pkg.sv
// Shared constants, register map and types of the two-wire channel controller
package ps2c_pkg;

  // System clock and the 2 MHz state machine time base
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned FSM_TICK_HZ = 2_000_000;
  localparam int unsigned TICK_DIV = CLK_FREQ_HZ / FSM_TICK_HZ;
  localparam int unsigned TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

  // Transmit timeout, counted in 2 MHz ticks
  localparam int unsigned TX_TIMEOUT_US = 25_000;
  localparam int unsigned TX_TIMEOUT_TICKS =
    TX_TIMEOUT_US * (FSM_TICK_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 16;

  // Instances and register map
  localparam int unsigned NUM_CH = 2;
  localparam logic [31:0] CH_BASE0 = 32'h0000_9000;
  localparam logic [31:0] CH_STRIDE = 32'h0000_0040;
  localparam int unsigned OFS_W = 6;
  localparam logic [OFS_W-1:0] OFS_BUFFER = 6'h00;
  localparam logic [OFS_W-1:0] OFS_CONTROL = 6'h04;
  localparam logic [OFS_W-1:0] OFS_STATUS = 6'h08;

  // Reset values
  localparam logic [7:0] RX_BUF_RESET = 8'hFF;
  localparam logic [7:0] TX_BUF_RESET = 8'h00;

  // Control fields
  localparam int unsigned CTL_DIR_BIT = 0;
  localparam int unsigned CTL_EN_BIT = 1;

  // Status fields
  localparam int unsigned ST_RX_VALID_BIT = 0;
  localparam int unsigned ST_TX_IDLE_BIT = 1;
  localparam int unsigned ST_RX_ERR_BIT = 2;
  localparam int unsigned ST_TX_TIMEOUT_BIT = 3;
  localparam int unsigned ST_RX_BUSY_BIT = 4;

  // Frame layout, in falling clock edges
  localparam logic [3:0] FRAME_EDGES = 4'hB;
  localparam logic [3:0] PARITY_EDGE = 4'hA;
  localparam logic [3:0] FIRST_EDGE = 4'h1;

  // Edges seen this soon after our own clock drive are our own echo
  localparam int unsigned ECHO_GUARD = 3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ps2c_req_type;

  typedef enum logic [1:0] {
    PS2C_IDLE,
    PS2C_RX,
    PS2C_TX
  } ps2c_state_type;

endpackage

//--- src/ps2c_top.sv
// Two-wire keyboard/mouse channel controller: channel logic and top
`timescale 1ns/10ps

// Summary of operation
// - Transfers happen only while the channel enable bit is set.
// - Enable cleared before the 10th falling edge: byte dropped, valid low.
// - Enable cleared after the 10th edge: byte kept if parity is good.
// - Direction select 0 receives, 1 transmits.
// - Receive, nothing pending: both lines released, wait for start bit.
// - Receive with byte pending: data released, clock held low.
// - Good frame: load buffer, set valid, pull clock low, stop receiving.
// - Reading the receive buffer clears valid; set to receive, it also releases the clock.
// - Receive buffer reloads FFh on read, on timeout and on reset.
// - Direction set while idle: clock low, data released until started.
// - Transmit buffer write starts sending; ignored if disabled, set to receive, or busy.
// - No transmission starts while a received byte is still unread.
// - Start: transmitter busy, data low, clock released in one cycle.
// - End on 11th edge or timeout: clear direction, idle, idle flag set.
// - Direction set mid-receive: drop before 10th edge, keep after.
// - Two instances at bases 9000h and 9040h, fixed offsets.
// - Offset 0 writes the transmit byte and reads the received byte.
// - Frame: start 0, eight data bits LSB first, odd parity, stop 1.
// - Timeouts run on a 2 MHz time base.
// - Disabled: clock line driven low, data line released.
module ps2c_channel #(
  parameter logic [31:0] BASE_ADDR = ps2c_pkg::CH_BASE0,
  parameter logic [ps2c_pkg::TIMER_W-1:0] TIMEOUT_TICKS =
    ps2c_pkg::TIMER_W'(ps2c_pkg::TX_TIMEOUT_TICKS)
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire ps2c_pkg::ps2c_req_type regReq,
  output logic [31:0] readData,
  // Link lines
  input wire logic linkClockLineIn,
  input wire logic linkDataLineIn,
  output logic linkClockLineOut,
  output logic linkClockLineOe,
  output logic linkDataLineOut,
  output logic linkDataLineOe
);

  // Link domain: one flop for the bit, one toggle per falling edge.
  // The clock stops between frames, so these carry no reset; the
  // power-up value only has to be defined, the echo guard hides it.
  logic linkBit_reg = 1'b1;
  logic linkTog_reg = 1'b0;

  always_ff @(negedge linkClockLineIn) begin
    linkBit_reg <= linkDataLineIn;
    linkTog_reg <= ~linkTog_reg;
  end

  // System domain
  logic [2:0] togSync_reg;
  logic [ps2c_pkg::ECHO_GUARD-1:0] heldHist_reg;
  logic [ps2c_pkg::TICK_W-1:0] tickCnt_reg;
  logic enable_reg, enable_next;
  logic dirSel_reg, dirSel_next;
  logic [7:0] rxBuf_reg, rxBuf_next;
  logic rxValid_reg, rxValid_next;
  logic rxErr_reg, rxErr_next;
  logic txTimeout_reg, txTimeout_next;
  logic txPending_reg, txPending_next;
  logic [9:0] txFrame_reg, txFrame_next;
  logic [8:0] rxShift_reg, rxShift_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [ps2c_pkg::TIMER_W-1:0] timer_reg, timer_next;
  logic clkOe_reg, clkOe_next;
  logic datOe_reg, datOe_next;
  ps2c_pkg::ps2c_state_type state_reg, state_next;

  // Decode
  wire inBlock = regReq.addr[31:ps2c_pkg::OFS_W] ==
                 BASE_ADDR[31:ps2c_pkg::OFS_W];
  wire [ps2c_pkg::OFS_W-1:0] ofs = regReq.addr[ps2c_pkg::OFS_W-1:0];
  wire selBuf = inBlock && (ofs == ps2c_pkg::OFS_BUFFER);
  wire selCtl = inBlock && (ofs == ps2c_pkg::OFS_CONTROL);
  wire selSt = inBlock && (ofs == ps2c_pkg::OFS_STATUS);
  wire wrTx = regReq.wr && selBuf;
  wire rdRx = regReq.rd && selBuf;
  wire wrCtl = regReq.wr && selCtl;
  wire rdSt = regReq.rd && selSt;

  // Edge events from the link; the first sync flop feeds only the second
  wire evtRaw = togSync_reg[2] ^ togSync_reg[1];
  // Our own clock pull makes a falling edge too; ignore edges while we
  // hold the line or just after releasing it
  wire evtOk = evtRaw && !clkOe_reg && (heldHist_reg == '0);
  wire evtBit = linkBit_reg;
  wire tick = tickCnt_reg == ps2c_pkg::TICK_LAST;
  wire [3:0] cntInc = bitCnt_reg + ps2c_pkg::FIRST_EDGE;
  wire parityOk = ^rxShift_reg;
  wire txIdleFlag = (state_reg != ps2c_pkg::PS2C_TX) && !txPending_reg;
  wire rxBusy = state_reg == ps2c_pkg::PS2C_RX;
  wire txAccept = wrTx && enable_reg && dirSel_reg && txIdleFlag;
  wire [7:0] txByte = regReq.wdata[7:0];

  // Read words
  wire [31:0] rxWord = {24'h0, rxBuf_reg};
  wire [31:0] ctlWord =
    ({31'h0, enable_reg} << ps2c_pkg::CTL_EN_BIT) |
    ({31'h0, dirSel_reg} << ps2c_pkg::CTL_DIR_BIT);
  wire [31:0] stWord =
    ({31'h0, rxValid_reg} << ps2c_pkg::ST_RX_VALID_BIT) |
    ({31'h0, txIdleFlag} << ps2c_pkg::ST_TX_IDLE_BIT) |
    ({31'h0, rxErr_reg} << ps2c_pkg::ST_RX_ERR_BIT) |
    ({31'h0, txTimeout_reg} << ps2c_pkg::ST_TX_TIMEOUT_BIT) |
    ({31'h0, rxBusy} << ps2c_pkg::ST_RX_BUSY_BIT);

  assign readData = !regReq.rd ? 32'h0 :
                    selBuf ? rxWord :
                    selCtl ? ctlWord :
                    selSt ? stWord : 32'h0;

  always_comb begin
    enable_next = enable_reg;
    dirSel_next = dirSel_reg;
    rxBuf_next = rxBuf_reg;
    rxValid_next = rxValid_reg;
    rxErr_next = rxErr_reg;
    txTimeout_next = txTimeout_reg;
    txPending_next = txPending_reg;
    txFrame_next = txFrame_reg;
    rxShift_next = rxShift_reg;
    bitCnt_next = bitCnt_reg;
    timer_next = timer_reg;
    datOe_next = datOe_reg;
    state_next = state_reg;

    // Register side effects
    if (rdRx) begin
      rxValid_next = 1'b0;
      rxBuf_next = ps2c_pkg::RX_BUF_RESET;
    end
    if (rdSt) begin
      rxErr_next = 1'b0;
      txTimeout_next = 1'b0;
    end
    if (txAccept) begin
      txFrame_next = {1'b1, ~^txByte, txByte};
      txPending_next = 1'b1;
    end

    case (state_reg)
      ps2c_pkg::PS2C_IDLE: begin
        if (evtOk && enable_reg && !dirSel_reg && !rxValid_reg &&
            !evtBit) begin
          state_next = ps2c_pkg::PS2C_RX;
          bitCnt_next = ps2c_pkg::FIRST_EDGE;
        end else if (txPending_reg && !rxValid_reg && enable_reg &&
                     dirSel_reg) begin
          state_next = ps2c_pkg::PS2C_TX;
          txPending_next = 1'b0;
          bitCnt_next = 4'h0;
          timer_next = '0;
          datOe_next = 1'b1;
        end
      end
      ps2c_pkg::PS2C_RX: begin
        if (!enable_reg || dirSel_reg) begin
          state_next = ps2c_pkg::PS2C_IDLE;
          // Past the parity edge the byte is complete enough to keep
          if (bitCnt_reg >= ps2c_pkg::PARITY_EDGE) begin
            if (parityOk) begin
              rxBuf_next = rxShift_reg[7:0];
              rxValid_next = 1'b1;
            end else begin
              rxErr_next = 1'b1;
            end
          end
        end else if (evtOk) begin
          bitCnt_next = cntInc;
          if (cntInc <= ps2c_pkg::PARITY_EDGE) begin
            rxShift_next = {evtBit, rxShift_reg[8:1]};
          end
          if (cntInc == ps2c_pkg::FRAME_EDGES) begin
            state_next = ps2c_pkg::PS2C_IDLE;
            if (parityOk && evtBit) begin
              rxBuf_next = rxShift_reg[7:0];
              rxValid_next = 1'b1;
            end else begin
              rxErr_next = 1'b1;
            end
          end
        end
      end
      ps2c_pkg::PS2C_TX: begin
        if (!enable_reg) begin
          state_next = ps2c_pkg::PS2C_IDLE;
        end else if (evtOk) begin
          bitCnt_next = cntInc;
          timer_next = '0;
          if (cntInc == ps2c_pkg::FRAME_EDGES) begin
            state_next = ps2c_pkg::PS2C_IDLE;
            dirSel_next = 1'b0;
          end else begin
            // Drive low for a 0, release for a 1; stop releases
            datOe_next = ~txFrame_reg[0];
            txFrame_next = {1'b1, txFrame_reg[9:1]};
          end
        end else if (tick) begin
          if (timer_reg == TIMEOUT_TICKS - 1'b1) begin
            state_next = ps2c_pkg::PS2C_IDLE;
            dirSel_next = 1'b0;
            txTimeout_next = 1'b1;
            rxBuf_next = ps2c_pkg::RX_BUF_RESET;
          end else begin
            timer_next = timer_reg + 1'b1;
          end
        end
      end
      default: begin
        state_next = ps2c_pkg::PS2C_IDLE;
      end
    endcase

    // Software writes win over the hardware clear of direction
    if (wrCtl) begin
      enable_next = regReq.wdata[ps2c_pkg::CTL_EN_BIT];
      dirSel_next = regReq.wdata[ps2c_pkg::CTL_DIR_BIT];
    end
    if (!enable_next || !dirSel_next) begin
      txPending_next = 1'b0;
    end
    // A disable mid-send lets data go at once, before the abort to idle
    if ((state_next != ps2c_pkg::PS2C_TX) || !enable_next) begin
      datOe_next = 1'b0;
    end
  end

  // Clock line: low while disabled, while a byte waits, while armed
  assign clkOe_next = !enable_next || rxValid_next ||
    ((state_next == ps2c_pkg::PS2C_IDLE) && dirSel_next);

  always_ff @(posedge clk) begin
    if (rst) begin
      togSync_reg <= 3'h0;
      heldHist_reg <= '1;
      tickCnt_reg <= '0;
    end else begin
      togSync_reg <= {togSync_reg[1:0], linkTog_reg};
      heldHist_reg <= {heldHist_reg[ps2c_pkg::ECHO_GUARD-2:0], clkOe_reg};
      tickCnt_reg <= tick ? '0 : tickCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
      dirSel_reg <= 1'b0;
      rxBuf_reg <= ps2c_pkg::RX_BUF_RESET;
      rxValid_reg <= 1'b0;
      rxErr_reg <= 1'b0;
      txTimeout_reg <= 1'b0;
      txPending_reg <= 1'b0;
      txFrame_reg <= {2'h3, ps2c_pkg::TX_BUF_RESET};
      rxShift_reg <= 9'h000;
      bitCnt_reg <= 4'h0;
      timer_reg <= '0;
      state_reg <= ps2c_pkg::PS2C_IDLE;
    end else begin
      enable_reg <= enable_next;
      dirSel_reg <= dirSel_next;
      rxBuf_reg <= rxBuf_next;
      rxValid_reg <= rxValid_next;
      rxErr_reg <= rxErr_next;
      txTimeout_reg <= txTimeout_next;
      txPending_reg <= txPending_next;
      txFrame_reg <= txFrame_next;
      rxShift_reg <= rxShift_next;
      bitCnt_reg <= bitCnt_next;
      timer_reg <= timer_next;
      state_reg <= state_next;
    end
  end

  // Pin drivers; open drain, so the driven level is always low
  always_ff @(posedge clk) begin
    if (rst) begin
      clkOe_reg <= 1'b1;
      datOe_reg <= 1'b0;
      linkClockLineOut <= 1'b0;
      linkDataLineOut <= 1'b0;
    end else begin
      clkOe_reg <= clkOe_next;
      datOe_reg <= datOe_next;
      linkClockLineOut <= 1'b0;
      linkDataLineOut <= 1'b0;
    end
  end

  assign linkClockLineOe = clkOe_reg;
  assign linkDataLineOe = datOe_reg;

endmodule

module ps2c_top #(
  parameter int unsigned NUM_CH = ps2c_pkg::NUM_CH,
  parameter logic [ps2c_pkg::TIMER_W-1:0] TX_TIMEOUT_TICKS =
    ps2c_pkg::TIMER_W'(ps2c_pkg::TX_TIMEOUT_TICKS)
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire ps2c_pkg::ps2c_req_type regReq,
  output logic [31:0] regRdata,
  output logic regRvalid,
  // Link lines, one per channel
  input wire logic [NUM_CH-1:0] linkClockLineIn,
  input wire logic [NUM_CH-1:0] linkDataLineIn,
  output logic [NUM_CH-1:0] linkClockLineOut,
  output logic [NUM_CH-1:0] linkClockLineOe,
  output logic [NUM_CH-1:0] linkDataLineOut,
  output logic [NUM_CH-1:0] linkDataLineOe
);

  logic [31:0] chRead [NUM_CH];
  logic [31:0] orChain [NUM_CH+1];

  assign orChain[0] = 32'h0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : gen_ch
      ps2c_channel #(
        .BASE_ADDR(ps2c_pkg::CH_BASE0 +
                   32'(gi) * ps2c_pkg::CH_STRIDE),
        .TIMEOUT_TICKS(TX_TIMEOUT_TICKS)
      ) u_ch (
        .clk(clk),
        .rst(rst),
        .regReq(regReq),
        .readData(chRead[gi]),
        .linkClockLineIn(linkClockLineIn[gi]),
        .linkDataLineIn(linkDataLineIn[gi]),
        .linkClockLineOut(linkClockLineOut[gi]),
        .linkClockLineOe(linkClockLineOe[gi]),
        .linkDataLineOut(linkDataLineOut[gi]),
        .linkDataLineOe(linkDataLineOe[gi])
      );
      assign orChain[gi+1] = orChain[gi] | chRead[gi];
    end
  endgenerate

  // Unmapped reads answer zero, since no channel claims them
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 32'h0;
      regRvalid <= 1'b0;
    end else begin
      regRdata <= orChain[NUM_CH];
      regRvalid <= regReq.rd;
    end
  end

endmodule

//--- verif/ps2c_monitor.sv
// Checker for the register port and the channel 0 link drives
`timescale 1ns/10ps
module ps2c_monitor #(
  parameter int unsigned NUM_CH = 2
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire ps2c_pkg::ps2c_req_type regReq,
  input wire logic [31:0] regRdata,
  input wire logic regRvalid,
  // Link drives
  input wire logic [NUM_CH-1:0] linkClockLineOe,
  input wire logic [NUM_CH-1:0] linkDataLineOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_rd_answer;
    regReq.rd && regReq.addr inside {32'h0000_9000, 32'h0000_9004,
      32'h0000_9008} |=> regRvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("mapped read not answered");

  property p_valid_cause;
    regRvalid |-> $past(regReq.rd);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("read data without a read");

  property p_rdata_idle;
    !regRvalid |-> regRdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");

  property p_buf_upper;
    regRvalid && $past(regReq.addr) == 32'h0000_9000 |->
      regRdata[31:8] == 24'h0;
  endproperty
  a_buf_upper: assert property (p_buf_upper)
    else $error("receive buffer upper bits set");

  property p_tx_start;
    $rose(linkDataLineOe[0]) |-> !linkClockLineOe[0];
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("data pulled while clock held");

  property p_dat_excl;
    linkDataLineOe[0] |-> !linkClockLineOe[0];
  endproperty
  a_dat_excl: assert property (p_dat_excl)
    else $error("both lines pulled low");

  // Clock is only let go in answer to the register port
  property p_clk_release;
    $fell(linkClockLineOe[0]) |-> $past(regReq.rd) || $past(regReq.rd, 2)
      || $past(regReq.wr)
      || $past(regReq.wr, 2) || $past(regReq.wr, 3);
  endproperty
  a_clk_release: assert property (p_clk_release)
    else $error("clock released without cause");

  property p_disable;
    regReq.wr && regReq.addr == 32'h0000_9004 && !regReq.wdata[1] |->
      ##[1:4] linkClockLineOe[0] && !linkDataLineOe[0];
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled channel lines wrong");
endmodule

bind ps2c_top ps2c_monitor #(.NUM_CH(NUM_CH)) i_mon (
  .clk(clk),
  .rst(rst),
  .regReq(regReq),
  .regRdata(regRdata),
  .regRvalid(regRvalid),
  .linkClockLineOe(linkClockLineOe),
  .linkDataLineOe(linkDataLineOe)
);

//--- verif/ps2c_peripheral.sv
// Behavioural keyboard/mouse end of the link; it makes the link clock
`timescale 1ns/10ps
module ps2c_peripheral (
  // Device drives, 1 pulls the line low
  devClkOe,
  devDatOe,
  // Resolved line levels
  clkLine,
  datLine
);
  input wire logic devClkOe;
  input wire logic devDatOe;
  output logic clkLine;
  output logic datLine;
  logic perClk = 1'b1;
  logic perDat = 1'b1;
  logic smp;
  int edges = 0;
  int halfNs = 80;
  // Open drain with pull-ups: a released line reads high
  assign clkLine = perClk & ~devClkOe;
  assign datLine = perDat & ~devDatOe;
  // Data is taken just before our falling edge, when the device is settled
  task automatic pulse();
    #(halfNs);
    smp = datLine;
    perClk = 1'b0;
    edges++;
    #(halfNs);
    perClk = 1'b1;
  endtask
  // Clock stands high outside frames
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] fr;
    fr = {1'b1, ~^b ^ bad, b, 1'b0};
    wait (clkLine === 1'b1);
    // Odd offset keeps our edges off the system clock's edges
    #207;
    for (int i = 0; i < 11; i++) begin
      perDat = fr[i];
      pulse();
    end
    perDat = 1'b1;
  endtask
  task automatic recv(output logic [10:0] fr);
    wait (devDatOe === 1'b1 && clkLine === 1'b1);
    #207;
    for (int i = 0; i < 11; i++) begin
      pulse();
      fr[i] = smp;
    end
  endtask
endmodule

//--- verif/tb_ps2c_top.sv
// Self-checking bench for the two-wire channel controller
`timescale 1ns/10ps
module tb_ps2c_top;
  localparam logic [31:0] ABUF = 32'h0000_9000;
  localparam logic [31:0] ACTL = 32'h0000_9004;
  localparam logic [31:0] AST = 32'h0000_9008;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk;
  logic rst;
  ps2c_pkg::ps2c_req_type regReq;
  logic [31:0] regRdata;
  logic regRvalid;
  logic [1:0] clkIn;
  logic [1:0] datIn;
  logic [1:0] clkOe;
  logic [1:0] datOe;
  logic [1:0] clkOut;
  logic [1:0] datOut;
  logic perClk;
  logic perDat;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [31:0] m;
  logic [7:0] rnd = 8'h3A;
  logic [7:0] b;
  logic [10:0] f;
  int numErrors = 0;
  int numChecks = 0;
  // Channel 1 has only its pull-ups attached
  assign clkIn = {~clkOe[1], perClk};
  assign datIn = {~datOe[1], perDat};

  ps2c_top #(.NUM_CH(2), .TX_TIMEOUT_TICKS(16'h0014)) i_dut (
    .clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
    .regRvalid(regRvalid), .linkClockLineIn(clkIn),
    .linkDataLineIn(datIn), .linkClockLineOut(clkOut),
    .linkClockLineOe(clkOe), .linkDataLineOut(datOut),
    .linkDataLineOe(datOe)
  );
  ps2c_peripheral i_per (.devClkOe(clkOe[0]), .devDatOe(datOe[0]),
    .clkLine(perClk), .datLine(perDat));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    if (numErrors == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic c, input logic d);
    // Open drain: the driven levels must stay low on both channels
    cmp({26'h0, clkOut, datOut, clkOe[0], datOe[0]}, {30'h0, c, d});
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic draw();
    rnd = lfsr(rnd);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    regReq = {1'b1, 1'b0, a, d};
    @(negedge clk);
    regReq = '0;
    // Control changes faster than the 2 MHz base are undefined
    repeat (25) @(negedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
      input logic [31:0] k);
    expQ.push_back(e & k);
    mskQ.push_back(k);
    @(negedge clk);
    regReq = {1'b0, 1'b1, a, 32'h0};
    @(negedge clk);
    regReq = '0;
    @(negedge clk);
  endtask
  task automatic abortRx(input int k, input logic [31:0] c, input logic keep);
    wr(ACTL, 32'h2);
    draw();
    i_per.edges = 0;
    fork
      i_per.send(rnd, 1'b0);
      begin
        wait (i_per.edges == k);
        // The edge needs a few system clocks to reach the state machine
        repeat (3) @(negedge clk);
        wr(ACTL, c);
      end
    join
    repeat (10) @(negedge clk);
    rd(AST, {31'h0, keep}, 32'h1);
    rd(ABUF, keep ? {24'h0, rnd} : 32'hFF, ALL);
  endtask

  always @(negedge clk) begin
    if (regRvalid === 1'b1) begin
      m = mskQ.pop_front();
      cmp(regRdata & m, expQ.pop_front());
    end
  end

  initial begin
    #500_000;
    numErrors++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    regReq = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    pin(1'b1, 1'b0);
    rd(ABUF, 32'hFF, ALL);
    rd(AST, 32'h2, 32'h3);
    rd(32'h0000_A000, 32'h0, ALL);
    wr(32'h0000_9044, 32'h2);
    cmp({31'h0, clkOe[1]}, 32'h0);
    pin(1'b1, 1'b0);
    wr(ACTL, 32'h2);
    pin(1'b0, 1'b0);
    draw();
    b = rnd;
    i_per.send(b, 1'b0);
    repeat (10) @(negedge clk);
    pin(1'b1, 1'b0);
    rd(AST, 32'h1, 32'h1);
    rd(ABUF, {24'h0, b}, ALL);
    pin(1'b0, 1'b0);
    rd(ABUF, 32'hFF, ALL);
    i_per.send(rnd, 1'b1);
    repeat (10) @(negedge clk);
    rd(AST, 32'h0, 32'h1);
    pin(1'b0, 1'b0);
    abortRx(4, 32'h0, 1'b0);
    abortRx(10, 32'h0, 1'b1);
    abortRx(4, 32'h3, 1'b0);
    abortRx(10, 32'h3, 1'b1);
    // An unread byte holds back the transmitter
    wr(ACTL, 32'h2);
    draw();
    b = rnd;
    i_per.send(b, 1'b0);
    wr(ACTL, 32'h3);
    draw();
    wr(ABUF, {24'h0, rnd});
    pin(1'b1, 1'b0);
    fork
      i_per.recv(f);
      rd(ABUF, {24'h0, b}, ALL);
    join
    cmp({21'h0, f}, {21'h0, 1'b1, ~^rnd, rnd, 1'b0});
    repeat (10) @(negedge clk);
    rd(AST, 32'h2, 32'h3);
    rd(ACTL, 32'h2, ALL);
    wr(ABUF, 32'h55);
    pin(1'b0, 1'b0);
    wr(ACTL, 32'h3);
    pin(1'b1, 1'b0);
    draw();
    fork
      i_per.recv(f);
      begin
        wr(ABUF, {24'h0, rnd});
        wr(ABUF, 32'h0);
      end
    join
    cmp({21'h0, f}, {21'h0, 1'b1, ~^rnd, rnd, 1'b0});
    repeat (10) @(negedge clk);
    pin(1'b0, 1'b0);
    wr(ACTL, 32'h1);
    wr(ABUF, 32'h0);
    pin(1'b1, 1'b0);
    wr(ACTL, 32'h3);
    wr(ABUF, 32'hA5);
    repeat (700) @(negedge clk);
    rd(AST, 32'hA, 32'hB);
    rd(ACTL, 32'h2, ALL);
    rd(ABUF, 32'hFF, ALL);
    complete_run();
  end
endmodule
